// file: core/eeprom_i2c_slave.sv
/*
 slave front end of the two-wire memory: conditions, byte framing, select match, ack.
 assumes the link clock is far slower than mclk; rst_b stands for the power-on reset.
*/
`timescale 1ns/1ps
module eeprom_i2c_slave #(
   parameter logic [2:0] SELECT_CODE = eeprom_i2c_pkg::SEL_POS0,
   parameter logic [15:0] PUD_CYCLES = 16'(eeprom_i2c_pkg::PUD_CYCLES)
) (
   input wire logic mclk,
   input wire logic rst_b,
   i2c_link_if.device lnk,
   input wire logic ack_ok,
   input wire logic [7:0] tx_data,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_ctrl,
   output logic rd_mode,
   output logic tx_take,
   output logic bus_busy,
   output logic standby
);
   typedef struct packed {
      eeprom_i2c_pkg::dev_state_t st;
      logic [eeprom_i2c_pkg::PUD_W-1:0] pud;
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic first;
      logic rd;
      logic oe;
      logic busy;
      logic standby;
      logic [7:0] rx_data;
      logic rx_valid;
      logic rx_ctrl;
      logic tx_take;
   } dev_reg_t;

   // idle bus reads high, so the synchronisers start high to avoid a false START
   localparam dev_reg_t DEV_RST = '{st: eeprom_i2c_pkg::D_PWR, scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
      sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1, default: '0};

   dev_reg_t r;
   dev_reg_t next_r;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic sel_match;

   // edges and bus conditions from the second and third synchroniser stages
   assign scl_rise = eeprom_i2c_pkg::rose(r.scl_d, r.scl_s2);
   assign scl_fall = eeprom_i2c_pkg::fell(r.scl_d, r.scl_s2);
   assign start_seen = r.scl_s2 & r.scl_d & eeprom_i2c_pkg::fell(r.sda_d, r.sda_s2);
   assign stop_seen = r.scl_s2 & r.scl_d & eeprom_i2c_pkg::rose(r.sda_d, r.sda_s2);
   // control code and fixed select bits, R/W in bit 0; the security area and protect register
   // sit behind the register code, their storage lives outside this front end
   assign sel_match = (r.sh[7:4] == eeprom_i2c_pkg::CODE_MEM || r.sh[7:4] == eeprom_i2c_pkg::CODE_REG)
      && r.sh[3:1] == SELECT_CODE;

   // whole next state; data line is only ever moved on a falling clock edge
   always_comb begin
      next_r = r;
      next_r.scl_s1 = lnk.scl;
      next_r.scl_s2 = r.scl_s1;
      next_r.scl_d = r.scl_s2;
      next_r.sda_s1 = lnk.sda;
      next_r.sda_s2 = r.sda_s1;
      next_r.sda_d = r.sda_s2;
      next_r.rx_valid = 1'b0;
      next_r.tx_take = 1'b0;
      unique case (r.st)
         eeprom_i2c_pkg::D_PWR: begin
            // ignore the bus until the power-up delay has run out
            next_r.pud = r.pud + 16'h0001;
            if (r.pud == PUD_CYCLES - 16'h0001) begin
               next_r.st = eeprom_i2c_pkg::D_IDLE;
               next_r.standby = 1'b1;
            end
         end
         eeprom_i2c_pkg::D_IDLE: begin
            next_r.oe = 1'b0;
         end
         eeprom_i2c_pkg::D_RX: begin
            if (scl_rise && r.cnt < eeprom_i2c_pkg::BYTE_BITS) begin
               next_r.sh = {r.sh[6:0], r.sda_s2};
               next_r.cnt = r.cnt + 4'h1;
            end
            if (scl_fall && r.cnt == eeprom_i2c_pkg::BYTE_BITS) begin
               next_r.rx_data = r.sh;
               next_r.rx_valid = 1'b1;
               next_r.rx_ctrl = r.first;
               if (r.first) begin
                  // control byte: answer only when selected and not busy inside
                  if (sel_match && ack_ok) begin
                     next_r.oe = 1'b1;
                     next_r.rd = r.sh[0];
                     next_r.first = 1'b0;
                     next_r.st = eeprom_i2c_pkg::D_ACK;
                  end else begin
                     next_r.st = eeprom_i2c_pkg::D_IDLE;
                  end
               end else begin
                  next_r.oe = 1'b1;
                  next_r.st = eeprom_i2c_pkg::D_ACK;
               end
            end
         end
         eeprom_i2c_pkg::D_ACK: begin
            // ninth pulse ends; start sending or go back to receiving
            if (scl_fall) begin
               next_r.cnt = 4'h0;
               if (r.rd) begin
                  next_r.sh = tx_data;
                  next_r.oe = ~tx_data[7];
                  next_r.tx_take = 1'b1;
                  next_r.st = eeprom_i2c_pkg::D_TX;
               end else begin
                  next_r.oe = 1'b0;
                  next_r.st = eeprom_i2c_pkg::D_RX;
               end
            end
         end
         eeprom_i2c_pkg::D_TX: begin
            if (scl_rise) begin
               next_r.cnt = r.cnt + 4'h1;
            end
            if (scl_fall) begin
               if (r.cnt == eeprom_i2c_pkg::BYTE_BITS) begin
                  next_r.oe = 1'b0;
                  next_r.st = eeprom_i2c_pkg::D_MACK;
               end else begin
                  next_r.sh = {r.sh[6:0], 1'b0};
                  next_r.oe = ~r.sh[6];
               end
            end
         end
         eeprom_i2c_pkg::D_MACK: begin
            // master ack keeps the sequential read going, nack ends it
            if (scl_rise) begin
               next_r.st = r.sda_s2 ? eeprom_i2c_pkg::D_IDLE : eeprom_i2c_pkg::D_ACK;
            end
         end
         default: begin
            next_r.st = eeprom_i2c_pkg::D_IDLE;
            next_r.oe = 1'b0;
         end
      endcase
      // conditions override any bit in flight
      if (r.st != eeprom_i2c_pkg::D_PWR) begin
         if (start_seen) begin
            next_r.st = eeprom_i2c_pkg::D_RX;
            next_r.cnt = 4'h0;
            next_r.first = 1'b1;
            next_r.oe = 1'b0;
            next_r.busy = 1'b1;
         end else if (stop_seen) begin
            next_r.st = eeprom_i2c_pkg::D_IDLE;
            next_r.cnt = 4'h0;
            next_r.oe = 1'b0;
            next_r.busy = 1'b0;
         end
      end
   end

   // single register stage; async reset models the power-on reset
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         r <= DEV_RST;
      end else begin
         r <= next_r;
      end
   end

   // open drain: the pin level is always low, only the enable moves
   assign lnk.sda_d_o = 1'b0;
   assign lnk.sda_d_oe = r.oe;
   assign rx_data = r.rx_data;
   assign rx_valid = r.rx_valid;
   assign rx_ctrl = r.rx_ctrl;
   assign rd_mode = r.rd;
   assign tx_take = r.tx_take;
   assign bus_busy = r.busy;
   assign standby = r.standby;
endmodule : eeprom_i2c_slave

// file: core/eeprom_i2c_pkg.sv
/*
 shared constants and types for the two-wire memory front end and its bus controller.
 assumes a 200 MHz mclk on both ends and an external pull-up on the data line.
*/
package eeprom_i2c_pkg;
   localparam int MCLK_NS = 5;
   // power_up_access_delay, figure as printed (max)
   localparam int PUD_US = 250;
   localparam int PUD_CYCLES = PUD_US * 1000 / MCLK_NS;
   localparam int PUD_W = 16;
   // quarter of a 1 us bus clock period
   localparam int SCL_QTR_NS = 250;
   localparam int SCL_QTR_CYCLES = SCL_QTR_NS / MCLK_NS;
   localparam int QTR_W = 8;
   localparam logic [3:0] CODE_MEM = 4'ha;
   localparam logic [3:0] CODE_REG = 4'hb;
   localparam logic [2:0] SEL_POS0 = 3'h0;
   localparam logic [2:0] SEL_POS7 = 3'h7;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [1:0] Q0 = 2'h0;
   localparam logic [1:0] Q1 = 2'h1;
   localparam logic [1:0] Q2 = 2'h2;
   localparam logic [1:0] Q3 = 2'h3;
   // controller register map, byte addresses
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_TXD = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;
   localparam logic [3:0] REG_RXD = 4'hc;
   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;
   localparam int CMD_WRITE = 2;
   localparam int CMD_READ = 3;
   localparam int CMD_NACK = 4;
   localparam int STAT_BUSY = 0;
   localparam int STAT_ACK = 1;
   localparam int STAT_READY = 2;

   typedef enum logic [5:0] {
      D_PWR = 6'h01, D_IDLE = 6'h02, D_RX = 6'h04, D_ACK = 6'h08, D_TX = 6'h10, D_MACK = 6'h20
   } dev_state_t;

   typedef enum logic [3:0] {
      M_IDLE = 4'h1, M_START = 4'h2, M_BIT = 4'h4, M_STOP = 4'h8
   } host_state_t;

   // rising edge of a synchronised level
   function automatic logic rose(input logic prev, input logic cur);
      return cur & ~prev;
   endfunction : rose

   function automatic logic fell(input logic prev, input logic cur);
      return prev & ~cur;
   endfunction : fell
endpackage : eeprom_i2c_pkg

// file: core/i2c_link_if.sv
/*
 two-wire link between the bus controller and the memory front end.
 resolves the open-drain data line from both enables; pull-up assumed.
*/
`timescale 1ns/1ps
interface i2c_link_if;
   logic scl;
   logic sda;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_d_o;
   logic sda_d_oe;

   // wired-and of both drivers over the pull-up
   assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);

   modport master (output scl, output sda_m_o, output sda_m_oe, input sda);
   modport device (input scl, output sda_d_o, output sda_d_oe, input sda);
endinterface : i2c_link_if

// file: core/i2c_host_ctrl.sv
/*
 two-wire bus master with an Avalon-MM register port (waitrequest).
 assumes software sequences control byte, address and data bytes itself.
*/
`timescale 1ns/1ps
module i2c_host_ctrl #(
   parameter logic [15:0] PUD_CYCLES = 16'(eeprom_i2c_pkg::PUD_CYCLES)
) (
   input wire logic mclk,
   input wire logic rst_b,
   i2c_link_if.master lnk,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   typedef struct packed {
      eeprom_i2c_pkg::host_state_t st;
      logic [eeprom_i2c_pkg::PUD_W-1:0] pud;
      logic ready;
      logic [eeprom_i2c_pkg::QTR_W-1:0] div;
      logic [1:0] q;
      logic [3:0] bi;
      logic [7:0] tx;
      logic [7:0] rx;
      logic [4:0] cmd;
      logic ack;
      logic scl;
      logic oe;
      logic sda_s1;
      logic sda_s2;
      logic waitreq;
      logic [31:0] rdata;
   } host_reg_t;

   localparam host_reg_t HOST_RST = '{st: eeprom_i2c_pkg::M_IDLE, scl: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
      waitreq: 1'b1, default: '0};
   localparam logic [7:0] QTR_LAST = 8'(eeprom_i2c_pkg::SCL_QTR_CYCLES - 1);

   host_reg_t r;
   host_reg_t next_r;
   logic busy;
   logic tick;

   assign busy = (r.st != eeprom_i2c_pkg::M_IDLE) | ~r.ready;
   assign tick = (r.div == QTR_LAST);

   always_comb begin
      next_r = r;
      next_r.sda_s1 = lnk.sda;
      next_r.sda_s2 = r.sda_s1;
      // hold off the first operation for the power-up delay
      if (!r.ready) begin
         next_r.pud = r.pud + 16'h0001;
         next_r.ready = (r.pud == PUD_CYCLES - 16'h0001);
      end
      // bus slave: one wait cycle, then a single cycle with waitrequest low
      next_r.waitreq = 1'b1;
      if ((avs_read || avs_write) && r.waitreq) begin
         next_r.waitreq = 1'b0;
         unique case (avs_address)
            eeprom_i2c_pkg::REG_STAT: next_r.rdata = {29'h0, r.ready, r.ack, busy};
            eeprom_i2c_pkg::REG_RXD: next_r.rdata = {24'h0, r.rx};
            eeprom_i2c_pkg::REG_TXD: next_r.rdata = {24'h0, r.tx};
            default: next_r.rdata = 32'h0;
         endcase
      end
      if (avs_write && !r.waitreq) begin
         if (avs_address == eeprom_i2c_pkg::REG_TXD && !busy) begin
            next_r.tx = avs_writedata[7:0];
         end
         if (avs_address == eeprom_i2c_pkg::REG_CMD && !busy) begin
            next_r.cmd = avs_writedata[4:0];
            next_r.bi = 4'h0;
            next_r.div = '0;
            next_r.q = eeprom_i2c_pkg::Q0;
            if (avs_writedata[eeprom_i2c_pkg::CMD_START]) begin
               next_r.st = eeprom_i2c_pkg::M_START;
            end else if (avs_writedata[eeprom_i2c_pkg::CMD_WRITE] || avs_writedata[eeprom_i2c_pkg::CMD_READ]) begin
               next_r.st = eeprom_i2c_pkg::M_BIT;
            end else if (avs_writedata[eeprom_i2c_pkg::CMD_STOP]) begin
               next_r.st = eeprom_i2c_pkg::M_STOP;
            end
         end
      end
      // quarter-period engine; bit data moves in quarter 0 or 3, clock low; START and STOP move it in quarter 2, clock high
      if (r.st != eeprom_i2c_pkg::M_IDLE) begin
         next_r.div = tick ? '0 : r.div + 8'h01;
      end
      if (tick) begin
         next_r.q = r.q + 2'h1;
         unique case (r.st)
            eeprom_i2c_pkg::M_START: begin
               unique case (r.q)
                  eeprom_i2c_pkg::Q0: next_r.oe = 1'b0;
                  eeprom_i2c_pkg::Q1: next_r.scl = 1'b1;
                  eeprom_i2c_pkg::Q2: next_r.oe = 1'b1;
                  eeprom_i2c_pkg::Q3: begin
                     next_r.scl = 1'b0;
                     if (r.cmd[eeprom_i2c_pkg::CMD_WRITE] || r.cmd[eeprom_i2c_pkg::CMD_READ]) begin
                        next_r.st = eeprom_i2c_pkg::M_BIT;
                     end else if (r.cmd[eeprom_i2c_pkg::CMD_STOP]) begin
                        next_r.st = eeprom_i2c_pkg::M_STOP;
                     end else begin
                        next_r.st = eeprom_i2c_pkg::M_IDLE;
                     end
                  end
               endcase
            end
            eeprom_i2c_pkg::M_BIT: begin
               unique case (r.q)
                  eeprom_i2c_pkg::Q0: begin
                     if (r.bi == eeprom_i2c_pkg::BYTE_BITS) begin
                        next_r.oe = r.cmd[eeprom_i2c_pkg::CMD_READ] & ~r.cmd[eeprom_i2c_pkg::CMD_NACK];
                     end else begin
                        next_r.oe = r.cmd[eeprom_i2c_pkg::CMD_WRITE] & ~r.tx[7];
                     end
                  end
                  eeprom_i2c_pkg::Q1: next_r.scl = 1'b1;
                  eeprom_i2c_pkg::Q2: begin
                     if (r.bi == eeprom_i2c_pkg::BYTE_BITS) begin
                        next_r.ack = ~r.sda_s2;
                     end else if (r.cmd[eeprom_i2c_pkg::CMD_READ]) begin
                        next_r.rx = {r.rx[6:0], r.sda_s2};
                     end
                  end
                  eeprom_i2c_pkg::Q3: begin
                     next_r.scl = 1'b0;
                     next_r.oe = 1'b0;
                     next_r.tx = {r.tx[6:0], 1'b0};
                     next_r.bi = r.bi + 4'h1;
                     if (r.bi == eeprom_i2c_pkg::BYTE_BITS) begin
                        next_r.st = r.cmd[eeprom_i2c_pkg::CMD_STOP] ? eeprom_i2c_pkg::M_STOP : eeprom_i2c_pkg::M_IDLE;
                     end
                  end
               endcase
            end
            eeprom_i2c_pkg::M_STOP: begin
               unique case (r.q)
                  eeprom_i2c_pkg::Q0: next_r.oe = 1'b1;
                  eeprom_i2c_pkg::Q1: next_r.scl = 1'b1;
                  eeprom_i2c_pkg::Q2: next_r.oe = 1'b0;
                  eeprom_i2c_pkg::Q3: next_r.st = eeprom_i2c_pkg::M_IDLE;
               endcase
            end
            default: next_r.st = eeprom_i2c_pkg::M_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         r <= HOST_RST;
      end else begin
         r <= next_r;
      end
   end

   assign lnk.scl = r.scl;
   assign lnk.sda_m_o = 1'b0;
   assign lnk.sda_m_oe = r.oe;
   assign avs_readdata = r.rdata;
   assign avs_waitrequest = r.waitreq;
endmodule : i2c_host_ctrl

// file: sim/eeprom_i2c_checker.sv
/*
 link checker: watches the two-wire link between the bus controller and the front end.
 assumes scl is launched from mclk, so sampling the link on mclk is safe.
*/
`timescale 1ns/1ps
module eeprom_i2c_checker #(
   parameter int PUD_CYCLES = 20,
   parameter logic [2:0] SELECT_CODE = 3'h0
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_m_o,
   input wire logic sda_m_oe,
   input wire logic sda_d_o,
   input wire logic sda_d_oe
);
   typedef struct packed {
      logic scl_q;
      logic sda_q;
      logic first;
      logic rd;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [15:0] pud;
   } chk_state_t;
   chk_state_t st;
   chk_state_t next_st;
   logic match;

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   // control byte in the shifter addresses this front end
   assign match = (st.sh[7:4] == eeprom_i2c_pkg::CODE_MEM || st.sh[7:4] == eeprom_i2c_pkg::CODE_REG)
      && st.sh[3:1] == SELECT_CODE;

   // bit counter; a stop needs no action, the next start restarts framing anyway
   always_comb begin
      next_st = st;
      next_st.scl_q = scl;
      next_st.sda_q = sda;
      if (st.pud < 16'(PUD_CYCLES)) next_st.pud = st.pud + 16'h0001;
      if (st.scl_q && scl && st.sda_q && !sda) begin
         next_st.cnt = 4'h0;
         next_st.first = 1'b1;
         next_st.rd = 1'b0;
      end else if (!st.scl_q && scl) begin
         next_st.sh = {st.sh[6:0], sda};
         next_st.cnt = (st.cnt == 4'h8) ? 4'h0 : st.cnt + 4'h1;
         if (st.cnt == 4'h8) next_st.first = 1'b0;
         if (st.cnt == 4'h7 && st.first) next_st.rd = sda;
      end
   end

   // cleared state may fake one scl rise after reset; the first start undoes it
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) st <= '0;
      else st <= next_st;
   end

   sequence ninth_fall_s;
      $fell(scl) && st.cnt == 4'h0 && sda_d_oe && !st.rd;
   endsequence
   sequence ctrl_ack_s;
      $rose(scl) && st.cnt == 4'h8 && st.first;
   endsequence

   dev_pull_low_a: assert property (sda_d_oe |-> !sda_d_o)
      else $error("front end drives data line high");
   host_pull_low_a: assert property (sda_m_oe |-> !sda_m_o)
      else $error("controller drives data line high");
   dev_edge_low_a: assert property ($changed(sda_d_oe) |-> !scl)
      else $error("front end moved data line with clock high");
   dev_silent_a: assert property (st.pud < 16'(PUD_CYCLES) |-> !sda_d_oe)
      else $error("front end drove the link before power-up delay");
   ack_slot_a: assert property ($rose(sda_d_oe) && (st.first || !st.rd) |-> st.cnt == 4'h8)
      else $error("acknowledge outside the ninth bit");
   ack_release_a: assert property (ninth_fall_s |-> ##[1:8] !sda_d_oe)
      else $error("acknowledge held past the ninth clock");
   no_match_nack_a: assert property (ctrl_ack_s ##0 !match |-> sda)
      else $error("foreign control byte acknowledged");
   ack_drop_a: assert property ($fell(sda_d_oe) && (st.first || !st.rd) |-> st.cnt == 4'h0)
      else $error("acknowledge dropped at wrong bit");
endmodule : eeprom_i2c_checker

// file: sim/tb_eeprom_i2c_slave_front_end.sv
/*
 bench: controller and front end joined by the link; software side driven over Avalon-MM.
 assumes both ends use a shortened power-up delay of 20 mclk cycles.
*/
`timescale 1ns/1ps
module tb_eeprom_i2c_slave_front_end;
   localparam logic [15:0] PUD = 16'h0014;
   localparam logic [2:0] SEL = eeprom_i2c_pkg::SEL_POS7;
   logic mclk;
   logic rst_b;
   logic ack_ok;
   logic [7:0] tx_data;
   logic [7:0] rx_data;
   logic rx_valid;
   logic rx_ctrl;
   logic rd_mode;
   logic tx_take;
   logic bus_busy;
   logic standby;
   logic [3:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] last_rx;
   logic last_ctrl;
   logic [31:0] q;
   int k;
   int n_fail;
   int n_tests;

   i2c_link_if lnk();
   eeprom_i2c_slave #(.SELECT_CODE(SEL), .PUD_CYCLES(PUD)) i_eeprom_i2c_slave (.mclk(mclk), .rst_b(rst_b),
      .lnk(lnk.device), .ack_ok(ack_ok), .tx_data(tx_data), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ctrl(rx_ctrl), .rd_mode(rd_mode), .tx_take(tx_take), .bus_busy(bus_busy), .standby(standby));
   i2c_host_ctrl #(.PUD_CYCLES(PUD)) i_i2c_host_ctrl (.mclk(mclk), .rst_b(rst_b), .lnk(lnk.master),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   eeprom_i2c_checker #(.PUD_CYCLES(int'(PUD)), .SELECT_CODE(SEL)) i_eeprom_i2c_checker (.mclk(mclk), .rst_b(rst_b),
      .scl(lnk.scl), .sda(lnk.sda), .sda_m_o(lnk.sda_m_o), .sda_m_oe(lnk.sda_m_oe), .sda_d_o(lnk.sda_d_o),
      .sda_d_oe(lnk.sda_d_oe));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // catch one-cycle pulses; next read byte is the inverse, so each load is told apart
   always @(posedge mclk) begin
      if (rx_valid === 1'b1) begin
         last_rx <= rx_data;
         last_ctrl <= rx_ctrl;
      end
      // single driver for tx_data; the first byte offered is c3
      if (!rst_b) begin
         tx_data <= 8'hc3;
      end else if (tx_take === 1'b1) begin
         tx_data <= ~tx_data;
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task end_sim;
      $display("tests=%0d fails=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim

   // one Avalon access, called just after a rising edge; the request stands until the edge at
   // which waitrequest is sampled low, read data is taken there, then one idle edge follows
   task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int i;
      i = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      do begin
         @(posedge mclk);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 50);
      if (avs_waitrequest !== 1'b0) begin
         n_fail++;
         end_sim();
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask : av

   // load a byte, launch a command and poll until the engine is idle
   task run(input logic [7:0] cmd, input logic [7:0] txd);
      int i;
      i = 0;
      av(1'b1, eeprom_i2c_pkg::REG_TXD, {24'h0, txd});
      av(1'b1, eeprom_i2c_pkg::REG_CMD, {24'h0, cmd});
      do begin
         av(1'b0, eeprom_i2c_pkg::REG_STAT, 32'h0);
         i++;
      end while (q[eeprom_i2c_pkg::STAT_BUSY] !== 1'b0 && i < 2000);
      if (i >= 2000) begin
         n_fail++;
         end_sim();
      end
   endtask : run

   task wb(input logic st, input logic sp, input logic [7:0] b, input logic ack);
      run(8'((st << eeprom_i2c_pkg::CMD_START) | (sp << eeprom_i2c_pkg::CMD_STOP)
         | (1 << eeprom_i2c_pkg::CMD_WRITE)), b);
      chk(32'(q[eeprom_i2c_pkg::STAT_ACK]), 32'(ack));
      if (ack) chk(32'({last_ctrl, last_rx}), 32'({st, b}));
   endtask : wb

   task rb(input logic nk, input logic sp, input logic [7:0] exp);
      run(8'((1 << eeprom_i2c_pkg::CMD_READ) | (nk << eeprom_i2c_pkg::CMD_NACK)
         | (sp << eeprom_i2c_pkg::CMD_STOP)), 8'h00);
      av(1'b0, eeprom_i2c_pkg::REG_RXD, 32'h0);
      chk(q, {24'h0, exp});
   endtask : rb

   // main sequence: power-up, writes, refusals, then a two-byte read
   initial begin
      rst_b = 1'b0;
      ack_ok = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      n_fail = 0;
      n_tests = 0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      chk(32'({standby, lnk.sda_d_oe, bus_busy}), 32'h0);
      // during the power-up delay the controller reports busy and not ready
      av(1'b0, eeprom_i2c_pkg::REG_STAT, 32'h0);
      chk(q, 32'h1);
      k = 0;
      do begin
         av(1'b0, eeprom_i2c_pkg::REG_STAT, 32'h0);
         k++;
      end while (q[eeprom_i2c_pkg::STAT_READY] !== 1'b1 && k < 100);
      if (q[eeprom_i2c_pkg::STAT_READY] !== 1'b1) begin
         n_fail++;
         end_sim();
      end
      chk(32'(standby), 32'h1);
      wb(1'b1, 1'b0, {eeprom_i2c_pkg::CODE_MEM, SEL, 1'b0}, 1'b1);
      chk(32'({bus_busy, rd_mode}), 32'h2);
      for (k = 0; k < 4; k++) wb(1'b0, 1'b0, 8'h5a ^ 8'(k * 8'h6d), 1'b1);
      wb(1'b0, 1'b1, 8'h81, 1'b1);
      chk(32'(bus_busy), 32'h0);
      wb(1'b1, 1'b1, {eeprom_i2c_pkg::CODE_REG, SEL, 1'b0}, 1'b1);
      wb(1'b1, 1'b1, {eeprom_i2c_pkg::CODE_MEM, eeprom_i2c_pkg::SEL_POS0, 1'b0}, 1'b0);
      wb(1'b1, 1'b1, {4'h9, SEL, 1'b0}, 1'b0);
      ack_ok <= 1'b0;
      wb(1'b1, 1'b1, {eeprom_i2c_pkg::CODE_MEM, SEL, 1'b0}, 1'b0);
      ack_ok <= 1'b1;
      // bare START, then a STOP after one stray clock: the abandoned bit must not upset the next frame
      run(8'(1 << eeprom_i2c_pkg::CMD_START), 8'h00);
      chk(32'(bus_busy), 32'h1);
      run(8'(1 << eeprom_i2c_pkg::CMD_STOP), 8'h00);
      chk(32'(bus_busy), 32'h0);
      wb(1'b1, 1'b0, {eeprom_i2c_pkg::CODE_MEM, SEL, 1'b1}, 1'b1);
      chk(32'(rd_mode), 32'h1);
      rb(1'b0, 1'b0, 8'hc3);
      rb(1'b1, 1'b1, 8'h3c);
      chk(32'(bus_busy), 32'h0);
      end_sim();
   end
endmodule : tb_eeprom_i2c_slave_front_end
